// [design/mem_space_map.svh]
`ifndef MEM_SPACE_MAP_SVH
`define MEM_SPACE_MAP_SVH
`define RF_ADDR_W 12
`define PM_ADDR_W 16
`define RF_CTRL_BASE 12'hF00
`define RF_CTRL_TOP 12'hFFF
`define RF_RAM_BASE 12'h000
`define RF_RAM_BYTES_MIN 1024
`define PM_FLASH_BYTES_MAX 4096
`define PM_UNIMPL_DATA 8'hFF
`define PM_OPT_BASE 16'h0000
`define PM_RESET_VEC 16'h0002
`define PM_WATCHDOG_VEC 16'h0004
`define PM_ILLEGAL_TRAP 16'h0006
`define PM_IRQ_VEC_BASE 16'h0008
`define PM_IRQ_VEC_TOP 16'h0037
`define PM_RSVD_BASE 16'h0038
`define PM_OSC_TRAP_BASE 16'h003A
`define PM_OSC_TRAP_TOP 16'h003D
`define PM_CODE_BASE 16'h003E
`define INFO_BASE 16'hFE00
`define INFO_TOP 16'hFF7F
`define INFO_BYTES 128
`define INFO_SEL_BIT 7
`define INFO_PART_BASE 7'h40
`define INFO_PART_TOP 7'h53
`define INFO_CAL_HI_BASE 7'h60
`define INFO_PAD 8'hFF
`endif

// [design/mem_space_pkg.sv]
package mem_space_pkg;
    // Region a program memory access falls into
    typedef enum logic [1:0] {
        PM_FLASH = 2'h0,
        PM_INFO = 2'h1,
        PM_EMPTY = 2'h3
    } pm_region_t;

    // Region a register file access falls into
    typedef enum logic [1:0] {
        RF_RAM = 2'h0,
        RF_CTRL = 2'h1,
        RF_HOLE = 2'h3
    } rf_region_t;

    // Role of a low program memory address, for the core's fetch logic
    typedef enum logic [2:0] {
        LOW_OPTION = 3'h0,
        LOW_RESET = 3'h1,
        LOW_WATCHDOG = 3'h2,
        LOW_ILLEGAL = 3'h3,
        LOW_IRQ = 3'h4,
        LOW_RESERVED = 3'h5,
        LOW_OSC_FAIL = 3'h6,
        LOW_CODE = 3'h7
    } low_role_t;
endpackage : mem_space_pkg

// [design/mem_port_if.sv]
interface mem_port_if #(parameter int AW = 12);
    logic [AW-1:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport owner (output addr, output rd, output wr, output wdata, input rdata);
    modport array (input addr, input rd, input wr, input wdata, output rdata);
endinterface : mem_port_if

// [design/byte_ram.sv]
`include "mem_space_map.svh"

module byte_ram #(
    parameter int DEPTH = 1024,
    parameter int AW = 12
) (
    input wire logic i_clk_sys,
    mem_port_if.array port
);
    logic [7:0] mem [DEPTH];
    logic [7:0] rdata_q;

    // Only the low bits address the array; the owner gates out-of-range strobes
    localparam int IW = $clog2(DEPTH);
    wire [IW-1:0] index = port.addr[IW-1:0];

    always_ff @(posedge i_clk_sys) begin
        if (port.wr) begin
            mem[index] <= port.wdata;
        end
        if (port.rd) begin
            rdata_q <= mem[index];
        end
    end

    assign port.rdata = rdata_q;
endmodule : byte_ram

// [design/info_rom.sv]
`include "mem_space_map.svh"

module info_rom (
    input wire logic i_clk_sys,
    input wire logic [6:0] i_addr,
    input wire logic i_rd,
    input wire logic [159:0] i_part_id,
    input wire logic [511:0] i_calib_lo,
    input wire logic [255:0] i_calib_hi,
    output logic [7:0] o_rdata
);
    logic [7:0] rdata_q;
    logic [7:0] table_w [`INFO_BYTES];

    // No write path exists: contents are fixed strap values
    genvar g;
    generate
        for (g = 0; g < `INFO_BYTES; g++) begin : g_byte
            if (g < `INFO_PART_BASE) begin : g_cal_lo
                assign table_w[g] = i_calib_lo[g*8 +: 8];
            end else if (g <= `INFO_PART_TOP) begin : g_part
                assign table_w[g] = i_part_id[159-(g-`INFO_PART_BASE)*8 -: 8];
            end else if (g >= `INFO_CAL_HI_BASE) begin : g_cal_hi
                assign table_w[g] = i_calib_hi[(g-`INFO_CAL_HI_BASE)*8 +: 8];
            end else begin : g_rsvd
                assign table_w[g] = `INFO_PAD;
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys) begin
        if (i_rd) begin
            rdata_q <= table_w[i_addr];
        end
    end

    assign o_rdata = rdata_q;
endmodule : info_rom

// [design/mem_space_decoder.sv]
// Functional notes
// - The register file space has 4096 byte addresses split into RAM and control registers.
// - Control registers occupy register addresses F00H to FFFH.
// - Reads of reserved control addresses return undefined data.
// - On-chip RAM starts at 000H and its size of 256B to 1KB is a build parameter.
// - Addresses between RAM and the control region read undefined and ignore writes.
// - Program memory is 64KB and reads beyond flash return FFH.
// - Writes beyond implemented flash change nothing.
// - Flash of 1KB to 4KB starts at zero with code from 003EH to its last byte.
// - Low program memory holds options, reset, watchdog, trap, interrupt and oscillator vectors.
// - The separate data memory space has no memory attached.
// - The 128-byte information area is reachable only while page select bit 7 is one.
// - With the area enabled, reads in FE00H to FF7FH return information bytes.
// - The information area is read-only.
// - Info bytes 40H to 53H hold a left-aligned 20-character part name padded with FFH.
`include "mem_space_map.svh"

module mem_space_decoder #(
    parameter int RAM_BYTES = 1024,
    parameter int FLASH_BYTES = 4096,
    parameter logic [159:0] PART_ID = {20{8'hFF}}
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Register file port from the core
    input wire logic [11:0] i_rf_addr,
    input wire logic i_rf_rd,
    input wire logic i_rf_wr,
    input wire logic [7:0] i_rf_wdata,
    output logic [7:0] o_rf_rdata,
    output logic o_rf_rvalid,
    // Control register region handed to peripherals
    output logic o_ctrl_sel,
    output logic [7:0] o_ctrl_offset,
    output logic o_ctrl_rd,
    output logic o_ctrl_wr,
    output logic [7:0] o_ctrl_wdata,
    input wire logic [7:0] i_ctrl_rdata,
    // Program memory port from the core
    input wire logic [15:0] i_pm_addr,
    input wire logic i_pm_rd,
    input wire logic i_pm_wr,
    input wire logic [7:0] i_pm_wdata,
    output logic [7:0] o_pm_rdata,
    output logic o_pm_rvalid,
    output logic [2:0] o_pm_low_role,
    // Flash array, outside this block
    output logic [15:0] o_flash_addr,
    output logic o_flash_rd,
    output logic o_flash_wr,
    output logic [7:0] o_flash_wdata,
    input wire logic [7:0] i_flash_rdata,
    // Page select bit 7 and info-area strap contents
    input wire logic i_info_en,
    input wire logic [511:0] i_info_calib_lo,
    input wire logic [255:0] i_info_calib_hi,
    // Data memory space
    input wire logic [15:0] i_dm_addr,
    input wire logic i_dm_rd,
    input wire logic i_dm_wr,
    output logic [7:0] o_dm_rdata
);
    mem_port_if #(.AW(`RF_ADDR_W)) ram_port ();

    // Register file decode
    wire rf_is_ctrl = i_rf_addr >= `RF_CTRL_BASE;
    wire rf_is_ram = i_rf_addr < 12'(RAM_BYTES);
    mem_space_pkg::rf_region_t rf_region;
    assign rf_region = rf_is_ctrl ? mem_space_pkg::RF_CTRL :
                       rf_is_ram ? mem_space_pkg::RF_RAM : mem_space_pkg::RF_HOLE;

    assign ram_port.addr = i_rf_addr;
    assign ram_port.rd = i_rf_rd && rf_region == mem_space_pkg::RF_RAM;
    assign ram_port.wr = i_rf_wr && rf_region == mem_space_pkg::RF_RAM;
    assign ram_port.wdata = i_rf_wdata;

    // Reserved control addresses are forwarded; their data is the peripherals' own
    assign o_ctrl_sel = rf_region == mem_space_pkg::RF_CTRL;
    assign o_ctrl_offset = i_rf_addr[7:0];
    assign o_ctrl_rd = i_rf_rd && o_ctrl_sel;
    assign o_ctrl_wr = i_rf_wr && o_ctrl_sel;
    assign o_ctrl_wdata = i_rf_wdata;

    byte_ram #(.DEPTH(RAM_BYTES), .AW(12)) u_ram (
        .i_clk_sys(i_clk_sys),
        .port(ram_port.array)
    );

    mem_space_pkg::rf_region_t rf_region_q;
    logic rf_rvalid_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rf_region_q <= mem_space_pkg::RF_RAM;
            rf_rvalid_q <= 1'b0;
        end else begin
            rf_region_q <= rf_region;
            rf_rvalid_q <= i_rf_rd;
        end
    end

    // Hole reads are undefined; the RAM latch value is returned as a don't-care
    assign o_rf_rdata = rf_region_q == mem_space_pkg::RF_CTRL ? i_ctrl_rdata :
                        ram_port.rdata;
    assign o_rf_rvalid = rf_rvalid_q;

    // Program memory decode
    wire pm_in_info = i_pm_addr >= `INFO_BASE && i_pm_addr <= `INFO_TOP;
    wire pm_in_flash = i_pm_addr < 16'(FLASH_BYTES);
    wire info_hit = i_info_en && pm_in_info;
    mem_space_pkg::pm_region_t pm_region;
    assign pm_region = info_hit ? mem_space_pkg::PM_INFO :
                       pm_in_flash ? mem_space_pkg::PM_FLASH :
                       mem_space_pkg::PM_EMPTY;

    assign o_flash_addr = i_pm_addr;
    assign o_flash_rd = i_pm_rd && pm_region == mem_space_pkg::PM_FLASH;
    assign o_flash_wr = i_pm_wr && pm_in_flash && !info_hit;
    assign o_flash_wdata = i_pm_wdata;

    logic [7:0] info_rdata;
    info_rom u_info (
        .i_clk_sys(i_clk_sys),
        .i_addr(i_pm_addr[6:0]),
        .i_rd(i_pm_rd && info_hit),
        .i_part_id(PART_ID),
        .i_calib_lo(i_info_calib_lo),
        .i_calib_hi(i_info_calib_hi),
        .o_rdata(info_rdata)
    );

    mem_space_pkg::pm_region_t pm_region_q;
    logic pm_rvalid_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pm_region_q <= mem_space_pkg::PM_EMPTY;
            pm_rvalid_q <= 1'b0;
        end else begin
            pm_region_q <= pm_region;
            pm_rvalid_q <= i_pm_rd;
        end
    end

    // Flash answers one cycle after its read strobe, like the internal arrays
    assign o_pm_rdata = pm_region_q == mem_space_pkg::PM_INFO ? info_rdata :
                        pm_region_q == mem_space_pkg::PM_FLASH ? i_flash_rdata :
                        `PM_UNIMPL_DATA;
    assign o_pm_rvalid = pm_rvalid_q;

    // Low vector table roles
    mem_space_pkg::low_role_t low_role;
    assign low_role =
        i_pm_addr < `PM_RESET_VEC ? mem_space_pkg::LOW_OPTION :
        i_pm_addr < `PM_WATCHDOG_VEC ? mem_space_pkg::LOW_RESET :
        i_pm_addr < `PM_ILLEGAL_TRAP ? mem_space_pkg::LOW_WATCHDOG :
        i_pm_addr < `PM_IRQ_VEC_BASE ? mem_space_pkg::LOW_ILLEGAL :
        i_pm_addr <= `PM_IRQ_VEC_TOP ? mem_space_pkg::LOW_IRQ :
        i_pm_addr < `PM_OSC_TRAP_BASE ? mem_space_pkg::LOW_RESERVED :
        i_pm_addr <= `PM_OSC_TRAP_TOP ? mem_space_pkg::LOW_OSC_FAIL :
        mem_space_pkg::LOW_CODE;
    assign o_pm_low_role = low_role;

    // Data memory space is not populated; strobes are ignored
    wire dm_unused = ^{i_dm_addr, i_dm_rd, i_dm_wr};
    assign o_dm_rdata = {7'h00, dm_unused & 1'b0} | `PM_UNIMPL_DATA;
endmodule : mem_space_decoder

// [dv/mem_space_decoder_asserts.sv]
module mem_space_decoder_asserts #(
    parameter int RAM_BYTES = 1024,
    parameter int FLASH_BYTES = 4096,
    parameter logic [159:0] PART_ID = {160{1'b1}}
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [11:0] i_rf_addr,
    input wire logic i_rf_rd,
    input wire logic i_rf_wr,
    input wire logic o_rf_rvalid,
    input wire logic o_ctrl_sel,
    input wire logic [7:0] o_ctrl_offset,
    input wire logic o_ctrl_wr,
    input wire logic [15:0] i_pm_addr,
    input wire logic i_pm_rd,
    input wire logic [7:0] o_pm_rdata,
    input wire logic [2:0] o_pm_low_role,
    input wire logic o_flash_wr,
    input wire logic i_info_en,
    input wire logic [7:0] o_dm_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    wire ovl = i_info_en && i_pm_addr >= 16'hFE00 && i_pm_addr <= 16'hFF7F;
    ctrl_sel_a: assert property (o_ctrl_sel == (i_rf_addr >= 12'hF00))
        else $error("control select wrong");
    ctrl_offset_a: assert property (o_ctrl_sel |-> o_ctrl_offset == i_rf_addr[7:0])
        else $error("control offset wrong");
    ctrl_write_a: assert property (o_ctrl_wr == (i_rf_wr && o_ctrl_sel))
        else $error("control write strobe wrong");
    rf_answer_a: assert property (i_rf_rd |=> o_rf_rvalid)
        else $error("register read not answered");
    pm_blank_a: assert property (i_pm_rd && i_pm_addr >= FLASH_BYTES && !ovl
        |=> o_pm_rdata == 8'hFF) else $error("unimplemented read not FF");
    flash_guard_a: assert property (o_flash_wr |-> i_pm_addr < FLASH_BYTES && !ovl)
        else $error("flash write outside flash");
    part_id_a: assert property (i_pm_rd && ovl && i_pm_addr inside {[16'hFE40:16'hFE53]}
        |=> o_pm_rdata == PART_ID[159 - 8 * ($past(i_pm_addr) - 16'hFE40) -: 8])
        else $error("part name byte wrong");
    low_role_a: assert property (i_pm_addr == 16'h0004 |-> o_pm_low_role == 3'h2)
        else $error("watchdog vector role wrong");
    dm_empty_a: assert property (o_dm_rdata == 8'hFF)
        else $error("data memory not empty");
    info_read_c: cover property (i_pm_rd && ovl);
    ctrl_read_c: cover property (i_rf_rd && o_ctrl_sel);
    flash_write_c: cover property (o_flash_wr);
endmodule : mem_space_decoder_asserts

bind mem_space_decoder mem_space_decoder_asserts #(.RAM_BYTES(RAM_BYTES),
    .FLASH_BYTES(FLASH_BYTES), .PART_ID(PART_ID)) i_mem_space_decoder_asserts (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_rf_addr(i_rf_addr), .i_rf_rd(i_rf_rd),
    .i_rf_wr(i_rf_wr), .o_rf_rvalid(o_rf_rvalid), .o_ctrl_sel(o_ctrl_sel),
    .o_ctrl_offset(o_ctrl_offset), .o_ctrl_wr(o_ctrl_wr), .i_pm_addr(i_pm_addr),
    .i_pm_rd(i_pm_rd), .o_pm_rdata(o_pm_rdata), .o_pm_low_role(o_pm_low_role),
    .o_flash_wr(o_flash_wr), .i_info_en(i_info_en), .o_dm_rdata(o_dm_rdata));

// [dv/pm_far_side_model.sv]
module pm_far_side_model (
    input wire logic i_clk_sys,
    input wire logic [15:0] i_flash_addr,
    input wire logic i_flash_rd,
    input wire logic i_flash_wr,
    input wire logic [7:0] i_flash_wdata,
    input wire logic [7:0] i_ctrl_offset,
    input wire logic i_ctrl_rd,
    output logic [7:0] o_flash_rdata,
    output logic [7:0] o_ctrl_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4096];
    initial begin
        o_flash_rdata = 8'h00;
        o_ctrl_rdata = 8'h00;
        for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h3C;
    end
    // Idle lines toggle so a stale byte is never mistaken for an answer
    always @(posedge i_clk_sys) begin
        if (i_flash_wr) mem[i_flash_addr[11:0]] <= i_flash_wdata;
        o_flash_rdata <= i_flash_rd ? mem[i_flash_addr[11:0]] : ~o_flash_rdata;
        o_ctrl_rdata <= i_ctrl_rd ? ~i_ctrl_offset : ~o_ctrl_rdata;
    end
endmodule : pm_far_side_model

// [dv/mem_space_decoder_test.sv]
module mem_space_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [159:0] PID = {"TESTPART", {12{8'hFF}}};
    localparam logic [15:0] ROLE_AT [8] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006,
        16'h0008, 16'h0038, 16'h003A, 16'h003E};
    logic i_clk_sys = 1'b0, i_srst = 1'b1, rf_rd = 1'b0, rf_wr = 1'b0, pm_rd = 1'b0;
    logic pm_wr = 1'b0, info_en = 1'b0, dm_rd = 1'b0, rf_rv, pm_rv, c_sel, c_rd, c_wr, f_rd, f_wr;
    logic [11:0] rf_addr = 12'h000;
    logic [15:0] pm_addr = 16'h0000, f_addr;
    logic [7:0] rf_wd = 8'h00, pm_wd = 8'h00, rf_q, pm_q, c_q, c_off, c_wd, f_q, f_wd, dm_q;
    logic [2:0] role;
    logic [511:0] cal_lo;
    logic [255:0] cal_hi;
    int fails = 0, cmp_count = 0;
    always #10 i_clk_sys = ~i_clk_sys;
    mem_space_decoder #(.RAM_BYTES(256), .FLASH_BYTES(1024), .PART_ID(PID)) i_mem_space_decoder (
        .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_rf_addr(rf_addr), .i_rf_rd(rf_rd),
        .i_rf_wr(rf_wr), .i_rf_wdata(rf_wd), .o_rf_rdata(rf_q), .o_rf_rvalid(rf_rv),
        .o_ctrl_sel(c_sel), .o_ctrl_offset(c_off), .o_ctrl_rd(c_rd), .o_ctrl_wr(c_wr),
        .o_ctrl_wdata(c_wd), .i_ctrl_rdata(c_q), .i_pm_addr(pm_addr), .i_pm_rd(pm_rd),
        .i_pm_wr(pm_wr), .i_pm_wdata(pm_wd), .o_pm_rdata(pm_q), .o_pm_rvalid(pm_rv),
        .o_pm_low_role(role), .o_flash_addr(f_addr), .o_flash_rd(f_rd), .o_flash_wr(f_wr),
        .o_flash_wdata(f_wd), .i_flash_rdata(f_q), .i_info_en(info_en),
        .i_info_calib_lo(cal_lo), .i_info_calib_hi(cal_hi), .i_dm_addr(pm_addr),
        .i_dm_rd(dm_rd), .i_dm_wr(pm_wr), .o_dm_rdata(dm_q));
    pm_far_side_model i_pm_far_side_model (.i_clk_sys(i_clk_sys), .i_flash_addr(f_addr),
        .i_flash_rd(f_rd), .i_flash_wr(f_wr), .i_flash_wdata(f_wd), .i_ctrl_offset(c_off),
        .i_ctrl_rd(c_rd), .o_flash_rdata(f_q), .o_ctrl_rdata(c_q));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // One-cycle strobe; the answer is settled at the next falling edge
    task automatic rf_acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge i_clk_sys) {rf_addr, rf_wd, rf_wr, rf_rd} = {a, d, w, !w};
        @(negedge i_clk_sys) {rf_wr, rf_rd} = 2'b00;
    endtask : rf_acc
    task automatic pm_acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk_sys) {pm_addr, pm_wd, pm_wr, pm_rd} = {a, d, w, !w};
        @(negedge i_clk_sys) {pm_wr, pm_rd} = 2'b00;
    endtask : pm_acc
    task automatic s_rf;
        rf_acc(1'b1, 12'h000, 8'hA5);
        rf_acc(1'b1, 12'h0FF, 8'h5A);
        rf_acc(1'b1, 12'h100, 8'h33);
        rf_acc(1'b0, 12'h0FF, 8'h00);
        check(rf_q, 8'h5A);
        check(rf_rv, 1'b1);
        rf_acc(1'b0, 12'h000, 8'h00);
        check(rf_q, 8'hA5);
        rf_acc(1'b0, 12'hF40, 8'h00); // No reserved control writes are issued
        check(rf_q, 8'hBF);
        @(negedge i_clk_sys) {rf_addr, rf_wd, rf_wr} = {12'hF00, 8'hC6, 1'b1};
        #1 check({c_wr, c_sel, c_wd}, {2'b11, 8'hC6});
        @(negedge i_clk_sys) rf_wr = 1'b0;
    endtask : s_rf
    task automatic s_pm;
        pm_acc(1'b1, 16'h003E, 8'h77);
        pm_acc(1'b0, 16'h003E, 8'h00);
        check(pm_q, 8'h77);
        pm_acc(1'b0, 16'h03FF, 8'h00);
        check(pm_q, 8'hC3);
        // The model aliases on 12 bits, so a leaked write here would clobber 003E
        pm_acc(1'b1, 16'h103E, 8'h11);
        pm_acc(1'b0, 16'h003E, 8'h00);
        check(pm_q, 8'h77);
        pm_acc(1'b0, 16'h0400, 8'h00);
        check(pm_q, 8'hFF);
        check(pm_rv, 1'b1);
        for (int i = 0; i < 8; i++) begin
            @(negedge i_clk_sys) pm_addr = ROLE_AT[i];
            #1 check(role, 16'(i));
        end
    endtask : s_pm
    task automatic s_info;
        @(negedge i_clk_sys) info_en = 1'b1;
        pm_acc(1'b0, 16'hFE40, 8'h00);
        check(pm_q, 8'h54);
        pm_acc(1'b0, 16'hFE53, 8'h00);
        check(pm_q, 8'hFF);
        pm_acc(1'b1, 16'hFE40, 8'h00);
        pm_acc(1'b0, 16'hFE40, 8'h00);
        check(pm_q, 8'h54);
        pm_acc(1'b0, 16'hFE05, 8'h00);
        check(pm_q, 8'h05);
        pm_acc(1'b0, 16'hFE61, 8'h00);
        check(pm_q, 8'hA1);
        @(negedge i_clk_sys) {info_en, dm_rd} = 2'b01;
        pm_acc(1'b0, 16'hFE40, 8'h00);
        check(pm_q, 8'hFF);
        check(dm_q, 8'hFF);
    endtask : s_info
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    initial begin
        for (int n = 0; n < 64; n++) cal_lo[8*n +: 8] = n[7:0];
        for (int n = 0; n < 32; n++) cal_hi[8*n +: 8] = 8'hA0 + n[7:0];
        repeat (10) @(posedge i_clk_sys);
        @(negedge i_clk_sys) i_srst = 1'b0;
        s_rf();
        s_pm();
        s_info();
        report_and_stop();
    end
    initial begin
        #1ms fails++;
        report_and_stop();
    end
endmodule : mem_space_decoder_test
